//--- mdi_asserts.sv
`default_nettype none
module mdi_asserts
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// mac side
	input wire logic tx_clk,
	input wire logic rx_clk,
	input wire logic rx_dv,
	input wire logic rx_er,
	input wire logic [3:0] rxd,
	input wire logic system_clock_output,
	// line side
	input wire logic [3:0] line_tx_nib,
	input wire logic line_tx_stb,
	input wire logic line_rx_dv,
	input wire logic line_rx_err,
	input wire logic [3:0] line_rx_nib,
	input wire logic line_rx_take
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_clk_eq; tx_clk == rx_clk; endproperty
	a_clk_eq: assert property (p_clk_eq) else $error("rx_clk off");
	// tx_clk high one cycle on marks mii mode
	property p_rxd; line_rx_take && line_rx_dv && !line_rx_err ##1 tx_clk
		|-> rxd == $past(line_rx_nib); endproperty
	a_rxd: assert property (p_rxd) else $error("rxd wrong");
	property p_inv; line_rx_take && line_rx_dv && line_rx_err ##1 tx_clk
		|-> rxd == ~$past(line_rx_nib); endproperty
	a_inv: assert property (p_inv) else $error("rxd not corrupted");
	property p_er_dv; rx_er |-> rx_dv; endproperty
	a_er_dv: assert property (p_er_dv) else $error("rx_er without rx_dv");
	property p_sco_hi; $rose(system_clock_output) |=> ##[1:4] !system_clock_output; endproperty
	a_sco_hi: assert property (p_sco_hi) else $error("sysclk high long");
	property p_sco_lo; $fell(system_clock_output) |-> ##[1:5] system_clock_output; endproperty
	a_sco_lo: assert property (p_sco_lo) else $error("sysclk low long");
	property p_stb; line_tx_stb |=> !line_tx_stb; endproperty
	a_stb: assert property (p_stb) else $error("stb not a pulse");
	property p_hold; !line_tx_stb |-> $stable(line_tx_nib); endproperty
	a_hold: assert property (p_hold) else $error("nib moved");
endmodule : mdi_asserts

bind mdi_mac_if mdi_asserts chk_u (.ref_clk, .nrst, .tx_clk, .rx_clk, .rx_dv, .rx_er,
	.rxd, .system_clock_output, .line_tx_nib, .line_tx_stb, .line_rx_dv, .line_rx_err,
	.line_rx_nib, .line_rx_take);
`default_nettype wire

//--- mdi_mac_if.sv
// Decided for this implementation: register access over Wishbone and the register offsets.
`default_nettype none

module mdi_mac_if
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// mac transmit side
	input wire logic tx_en,
	input wire logic [3:0] txd,
	output logic tx_clk,
	// mac receive side
	output logic rx_clk,
	output logic rx_dv,
	output logic rx_er,
	output logic [3:0] rxd,
	output logic crs,
	output logic col,
	// system clock out
	output logic system_clock_output,
	// line transmit stream
	output logic line_tx_en,
	output logic [3:0] line_tx_nib,
	output logic line_tx_stb,
	// line receive stream
	input wire logic line_rx_carrier,
	input wire logic line_rx_dv,
	input wire logic line_rx_err,
	input wire logic [3:0] line_rx_nib,
	output logic line_rx_take
);

	mdi_pkg::mdi_state_s st;
	mdi_pkg::mdi_state_s next_st;

	logic [6:0] beat_period;
	logic [6:0] sys_period;
	logic beat_lvl;
	logic beat_tick;
	logic sys_lvl;
	logic wb_req;
	logic idle;
	logic [3:0] rx_corr;
	logic [31:0] stat_word;

	// data beat: mii clock period, or rmii dibit rate (slowed for 10M)
	always_comb
	begin
		if (st.act.rmii)
			beat_period = st.act.spd100 ? mdi_pkg::RMII_CYC : mdi_pkg::RMII10_CYC;
		else
			beat_period = st.act.spd100 ? mdi_pkg::MII100_CYC : mdi_pkg::MII10_CYC;
		sys_period = st.act.rmii ? mdi_pkg::RMII_CYC : mdi_pkg::MII100_CYC;
	end

	mdi_clkdiv u_beat
	(
		.ref_clk(ref_clk),
		.nrst(nrst),
		.period(beat_period),
		.hi_len({1'b0, beat_period[6:1]}),
		.lvl(beat_lvl),
		.tick(beat_tick)
	);

	// 50 MHz is an odd count of core cycles, so duty is 2 of 5
	mdi_clkdiv u_sys
	(
		.ref_clk(ref_clk),
		.nrst(nrst),
		.period(sys_period),
		.hi_len({1'b0, sys_period[6:1]}),
		.lvl(sys_lvl),
		.tick()
	);

	assign wb_req = wb_cyc_i & wb_stb_i & ~st.wb_ack;
	assign idle = ~tx_en & ~st.tx_en_d & ~line_rx_carrier & ~line_rx_dv & ~st.rx_dv;

	// corruption keeps timing but breaks the frame check
	assign rx_corr = line_rx_err ? ~line_rx_nib : line_rx_nib;

	always_comb
	begin
		stat_word = 32'h0000_0000;
		stat_word[mdi_pkg::STAT_CRS_BIT] = st.crs;
		stat_word[mdi_pkg::STAT_COL_BIT] = st.col;
		stat_word[mdi_pkg::STAT_RXDV_BIT] = st.rx_dv;
		stat_word[mdi_pkg::STAT_TXEN_BIT] = st.tx_en_d;
		stat_word[mdi_pkg::STAT_ACT_LSB +: 4] = st.act;
	end

	always_comb
	begin
		next_st = st;

		// wishbone: one wait state, ack for one cycle
		next_st.wb_ack = wb_req;
		next_st.wb_dat = 32'h0000_0000;
		if (wb_req)
		begin
			case (wb_adr_i & 8'hfc)
				mdi_pkg::CTRL_OFS:
				begin
					next_st.wb_dat = {28'h000_0000, st.cfg};
					if (wb_we_i && wb_sel_i[0])
						next_st.cfg = mdi_pkg::mdi_cfg_s'(wb_dat_i[3:0]);
				end
				mdi_pkg::STAT_OFS:
					next_st.wb_dat = stat_word;
				default:
					next_st.wb_dat = 32'h0000_0000;
			endcase
		end

		// a mode change mid-frame would split nibbles, so wait for idle
		if (idle)
			next_st.act = st.cfg;

		next_st.tx_en_d = tx_en;

		// transmit path
		next_st.line_tx_stb = 1'b0;
		if (beat_tick)
		begin
			if (!st.act.rmii)
			begin
				next_st.line_tx_en = tx_en;
				next_st.line_tx_nib = tx_en ? txd : 4'h0;
				next_st.line_tx_stb = 1'b1;
				next_st.tx_half = 1'b0;
			end
			else if (!tx_en)
			begin
				next_st.tx_half = 1'b0;
				next_st.line_tx_en = 1'b0;
				next_st.line_tx_nib = 4'h0;
				next_st.line_tx_stb = 1'b1;
			end
			else if (!st.tx_half)
			begin
				next_st.tx_lo = txd[1:0];
				next_st.tx_half = 1'b1;
			end
			else
			begin
				next_st.line_tx_en = 1'b1;
				next_st.line_tx_nib = {txd[1:0], st.tx_lo};
				next_st.line_tx_stb = 1'b1;
				next_st.tx_half = 1'b0;
			end
		end

		// receive path
		if (beat_tick)
		begin
			if (!st.act.rmii)
			begin
				next_st.rx_dv = line_rx_dv;
				next_st.rx_er = line_rx_dv & line_rx_err & st.act.spd100;
				next_st.rxd = line_rx_dv ? rx_corr : 4'h0;
				next_st.crs = line_rx_carrier;
				next_st.rx_half = 1'b0;
			end
			else if (!st.rx_half)
			begin
				next_st.rx_dv = line_rx_dv;
				next_st.rx_er = line_rx_dv & line_rx_err & st.act.spd100;
				next_st.rxd = line_rx_dv ? {2'b00, rx_corr[1:0]} : 4'h0;
				next_st.rx_hi = rx_corr[3:2];
				next_st.rx_half = line_rx_dv;
				// carrier gone with data left: low on first dibit
				next_st.crs = line_rx_carrier;
			end
			else
			begin
				next_st.rxd = {2'b00, st.rx_hi};
				next_st.rx_half = 1'b0;
				// and high on second, so the mac sees the toggle
				next_st.crs = line_rx_carrier | st.rx_dv;
			end
		end

		// heartbeat after each transmission in mii 10M half duplex
		if (st.hb_cnt != 9'h000)
			next_st.hb_cnt = st.hb_cnt - 9'h001;
		if (st.tx_en_d && !tx_en && st.act.hb && !st.act.spd100 && !st.act.fdx && !st.act.rmii)
			next_st.hb_cnt = mdi_pkg::HB_CYC;
		if (st.act.fdx || st.act.rmii)
			next_st.hb_cnt = 9'h000;

		// rmii has no collision pin; the mac works it out from crs_dv
		if (st.act.fdx || st.act.rmii)
			next_st.col = 1'b0;
		else
			next_st.col = (tx_en & line_rx_carrier) | (next_st.hb_cnt != 9'h000);
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st <= '0;
			st.cfg <= mdi_pkg::CTRL_RST;
			st.act <= mdi_pkg::CTRL_RST;
		end
		else
			st <= next_st;
	end

	// take is a handshake strobe: nibble is sampled in the same cycle
	assign line_rx_take = beat_tick & (~st.act.rmii | ~st.rx_half);

	assign tx_clk = beat_lvl & ~st.act.rmii;
	assign rx_clk = beat_lvl & ~st.act.rmii;
	assign system_clock_output = sys_lvl;

	assign wb_ack_o = st.wb_ack;
	assign wb_dat_o = st.wb_dat;
	assign rx_dv = st.rx_dv;
	assign rx_er = st.rx_er;
	assign rxd = st.rxd;
	assign crs = st.crs;
	assign col = st.col;
	assign line_tx_en = st.line_tx_en;
	assign line_tx_nib = st.line_tx_nib;
	assign line_tx_stb = st.line_tx_stb;

endmodule : mdi_mac_if

`default_nettype wire

//--- mdi_mac_model.sv
`default_nettype none
module mdi_mac_model
(
	// clocks
	input wire logic ref_clk,
	input wire logic tx_clk,
	// frame request
	input wire logic go,
	input wire logic [3:0] n,
	// mac pins
	output logic tx_en = 1'h0,
	output logic [3:0] txd = 4'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tq = 1'h0;
	logic [3:0] cnt = 4'h0;
	// collision is the mac's own job here, sysclk unused
	always @(posedge ref_clk)
	begin
		tq <= tx_clk;
		if (go)
			cnt <= n;
		else if (tx_clk && !tq)
		begin
			tx_en <= cnt != 4'h0;
			// idle data keeps changing so a stale value is never trusted
			txd <= (cnt != 4'h0) ? cnt : ~txd;
			if (cnt != 4'h0)
				cnt <= cnt - 4'h1;
		end
	end
endmodule : mdi_mac_model
`default_nettype wire

//--- mdi_pkg.sv
`default_nettype none

package mdi_pkg;

	// core clock rate, ref_clk
	localparam int CLK_MHZ = 250;

	// beat periods and the heartbeat time in ns, and the derived counts of ref_clk cycles
	localparam int MII100_PERIOD_NS = 40;
	localparam int MII10_PERIOD_NS = 400;
	localparam int RMII_PERIOD_NS = 20;
	localparam int RMII10_BEAT_NS = 200;
	localparam int HB_TIME_NS = 1000;

	localparam logic [6:0] MII100_CYC = 7'((MII100_PERIOD_NS * CLK_MHZ) / 1000);
	localparam logic [6:0] MII10_CYC = 7'((MII10_PERIOD_NS * CLK_MHZ) / 1000);
	localparam logic [6:0] RMII_CYC = 7'((RMII_PERIOD_NS * CLK_MHZ) / 1000);
	localparam logic [6:0] RMII10_CYC = 7'((RMII10_BEAT_NS * CLK_MHZ) / 1000);
	localparam logic [8:0] HB_CYC = 9'((HB_TIME_NS * CLK_MHZ) / 1000);

	// register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;

	// control field positions
	localparam int CTRL_RMII_BIT = 0;
	localparam int CTRL_SPD100_BIT = 1;
	localparam int CTRL_FDX_BIT = 2;
	localparam int CTRL_HB_BIT = 3;

	// status field positions
	localparam int STAT_CRS_BIT = 0;
	localparam int STAT_COL_BIT = 1;
	localparam int STAT_RXDV_BIT = 2;
	localparam int STAT_TXEN_BIT = 3;
	localparam int STAT_ACT_LSB = 4;

	typedef struct packed {
		logic hb;
		logic fdx;
		logic spd100;
		logic rmii;
	} mdi_cfg_s;

	// reset: mii, 100 Mb/s, half duplex, heartbeat on
	localparam mdi_cfg_s CTRL_RST = 4'ha;

	typedef struct packed {
		mdi_cfg_s cfg;
		mdi_cfg_s act;
		logic wb_ack;
		logic [31:0] wb_dat;
		logic tx_half;
		logic [1:0] tx_lo;
		logic line_tx_en;
		logic [3:0] line_tx_nib;
		logic line_tx_stb;
		logic tx_en_d;
		logic rx_half;
		logic [1:0] rx_hi;
		logic rx_dv;
		logic rx_er;
		logic [3:0] rxd;
		logic crs;
		logic [8:0] hb_cnt;
		logic col;
	} mdi_state_s;

	typedef struct packed {
		logic [6:0] cnt;
		logic lvl;
		logic tick;
	} mdi_div_s;

endpackage : mdi_pkg

// clock divider: square level plus a pulse on its rising edge
module mdi_clkdiv
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// shape
	input wire logic [6:0] period,
	input wire logic [6:0] hi_len,
	// output
	output logic lvl,
	output logic tick
);

	mdi_pkg::mdi_div_s st;
	mdi_pkg::mdi_div_s next_st;

	always_comb
	begin
		next_st = st;
		// a shorter new period must not strand the count above it
		if (st.cnt >= period - 7'h01)
			next_st.cnt = 7'h00;
		else
			next_st.cnt = st.cnt + 7'h01;
		next_st.lvl = next_st.cnt < hi_len;
		next_st.tick = next_st.cnt == 7'h00;
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			st <= '0;
		else
			st <= next_st;
	end

	assign lvl = st.lvl;
	assign tick = st.tick;

endmodule : mdi_clkdiv

`default_nettype wire

//--- tb.sv
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tx_en, tx_clk, rx_clk;
	logic rx_dv, rx_er, crs, col, system_clock_output, line_tx_en, line_tx_stb, go;
	logic line_rx_carrier, line_rx_dv, line_rx_err, line_rx_take;
	logic [7:0] wb_adr_i;
	logic [3:0] wb_sel_i, txd, rxd, line_tx_nib, line_rx_nib, n;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	int errors, compares, k, run, last;
	realtime t0;
	mdi_mac_if dut_u (.ref_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .tx_en, .txd, .tx_clk, .rx_clk, .rx_dv, .rx_er,
		.rxd, .crs, .col, .system_clock_output, .line_tx_en, .line_tx_nib, .line_tx_stb,
		.line_rx_carrier, .line_rx_dv, .line_rx_err, .line_rx_nib, .line_rx_take);
	mdi_mac_model mac_u (.ref_clk, .tx_clk, .go, .n, .tx_en, .txd);
	initial
	begin
		ref_clk = 1'h0;
		forever #2 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		run <= col ? run + 1 : 0;
		// each new frame starts a fresh collision record
		if (go)
			last <= 0;
		else if (!col && run != 0)
			last <= run;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e)
		begin
			errors++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		wb_cyc_i <= 1'h1;
		wb_stb_i <= 1'h1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge ref_clk); while (wb_ack_o !== 1'h1);
		q = wb_dat_o;
		wb_cyc_i <= 1'h0;
		wb_stb_i <= 1'h0;
	endtask : wb
	task automatic sw();
		k = 0;
		do
		begin
			@(posedge ref_clk);
			k++;
		end
		while (line_tx_stb !== 1'h1);
	endtask : sw
	task automatic tx(input logic [3:0] m, input int b, input logic c);
		n <= m;
		go <= 1'h1;
		@(posedge ref_clk);
		go <= 1'h0;
		do sw(); while (line_tx_en !== 1'h1);
		chk("nib", 32'(m), 32'(line_tx_nib));
		chk("col", 32'(c), 32'(col));
		for (int i = m - 1; i >= 0; i--)
		begin
			sw();
			chk("beat", b, k);
			chk("tx", i ? i + 16 : 0, 32'({line_tx_en, line_tx_nib}));
		end
	endtask : tx
	task automatic rx(input logic c, input logic d, input logic e, input logic [3:0] v);
		line_rx_carrier <= c;
		line_rx_dv <= d;
		line_rx_err <= e;
		line_rx_nib <= v;
		do @(posedge ref_clk); while (line_rx_take !== 1'h1);
		@(posedge ref_clk);
		chk("rx_dv", 32'(d), 32'(rx_dv));
		chk("rx_er", 32'(e), 32'(rx_er));
		chk("crs", 32'(c), 32'(crs));
		if (d)
			chk("rxd", 32'(v ^ {4{e}}), 32'(rxd));
	endtask : rx
	task automatic sp(input int e);
		@(posedge system_clock_output);
		t0 = $realtime;
		@(posedge system_clock_output);
		chk("sysclk", e, int'(($realtime - t0) / 4.0));
	endtask : sp
	task automatic test_done();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done
	initial
	begin
		{nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, go, n} = '0;
		{line_rx_carrier, line_rx_dv, line_rx_err, line_rx_nib} = '0;
		{errors, compares} = '0;
		wb_sel_i = 4'hf;
		repeat (10) @(posedge ref_clk);
		nrst <= 1'h1;
		wb(1'h0, mdi_pkg::CTRL_OFS, 32'h0);
		chk("ctrl", 32'ha, q);
		wb(1'h0, mdi_pkg::STAT_OFS, 32'h0);
		chk("stat", 32'ha0, q);
		wb(1'h0, 8'h40, 32'h0);
		chk("spare", 32'h0, q);
		rx(1'h1, 1'h1, 1'h0, 4'h5);
		rx(1'h1, 1'h1, 1'h1, 4'h6);
		rx(1'h0, 1'h0, 1'h0, 4'h0);
		sp(10);
		line_rx_carrier <= 1'h1;
		tx(4'h3, int'(mdi_pkg::MII100_CYC), 1'h1);
		line_rx_carrier <= 1'h0;
		wb(1'h1, mdi_pkg::CTRL_OFS, 32'h8);
		tx(4'h1, int'(mdi_pkg::MII10_CYC), 1'h0);
		repeat (300) @(posedge ref_clk);
		chk("heartbeat", 32'(mdi_pkg::HB_CYC), last);
		wb(1'h1, mdi_pkg::CTRL_OFS, 32'hc);
		line_rx_carrier <= 1'h1;
		tx(4'h1, int'(mdi_pkg::MII10_CYC), 1'h0);
		line_rx_carrier <= 1'h0;
		repeat (300) @(posedge ref_clk);
		chk("fdx col", 0, last);
		wb(1'h1, mdi_pkg::CTRL_OFS, 32'h3);
		sp(5);
		chk("tx_clk", 32'h0, 32'({tx_clk, rx_clk}));
		wb(1'h0, mdi_pkg::CTRL_OFS, 32'h0);
		chk("ctrl rd", 32'h3, q);
		rx(1'h1, 1'h1, 1'h0, 4'h2);
		rx(1'h1, 1'h1, 1'h1, 4'hd);
		rx(1'h0, 1'h0, 1'h0, 4'h0);
		test_done();
	end
	initial
	begin
		#100us;
		errors++;
		test_done();
	end
endmodule : tb
`default_nettype wire
